/* File: hdl/ai_timing_cfg.svh */
/*
 * Register offsets, field positions, reset values and timing counts for the
 * acquisition timing engine. Assumes a plain word-addressed register port.
 */
`ifndef AI_TIMING_CFG_SVH
`define AI_TIMING_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_CLKSEL      4'h1
`define REG_DIVIDER     4'h2
`define REG_DELAY       4'h3
`define REG_PRE_COUNT   4'h4
`define REG_POST_COUNT  4'h5
`define REG_COMMAND     4'h6
`define REG_STATUS      4'h7
`define REG_COUNT       4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_PRETRIG    0
`define CTRL_SW_START   1
`define CTRL_START_FALL 2
`define CTRL_REF_FALL   3
`define CLKSEL_EXT      0
`define CLKSEL_FALL     1
`define CLKSEL_SRC_LO   4
`define CMD_ARM         0
`define CMD_SW_START    1
`define CMD_SW_SAMPLE   2
`define CMD_STOP        3
`define CMD_CLR_DONE    4

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DIVIDER_RESET   32'h0000_0002
`define DELAY_RESET     32'h0000_0002
`define SYS_CLK_HZ      50000000

`endif

/* File: hdl/ai_timing_pkg.sv */
/*
 * Types for the acquisition timing engine.
 * Assumes the _cfg header supplies all numeric constants.
 */
package ai_timing_pkg;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_ARMED   = 3'b001,
		ST_DELAY   = 3'b011,
		ST_PRE     = 3'b010,
		ST_WAITREF = 3'b110,
		ST_POST    = 3'b111
	} acq_state_e;

	typedef enum logic [1:0] {
		SRC_COUNTER = 2'h0,
		SRC_DIVIDED = 2'h1,
		SRC_SOFT    = 2'h2
	} int_src_e;

	typedef struct packed {
		logic [15:0] programmable_function_input;
		logic [7:0]  trig_bus;
		logic        star;
		logic        analog_cmp;
	} ext_lines_s;

	typedef struct packed {
		acq_state_e  state;
		logic [31:0] count;
		logic [31:0] div_cnt;
		logic [31:0] dly_cnt;
		logic        clk_prev;
		logic        start_prev;
		logic        ref_prev;
		logic        done;
		logic        sample;
		logic        start_out;
		logic [31:0] rdata;
		logic        pretrig;
		logic        sw_start;
		logic        start_fall;
		logic        ref_fall;
		logic        ext_clk;
		logic        clk_fall;
		logic [4:0]  src_sel;
		logic [31:0] divider;
		logic [31:0] delay;
		logic [31:0] pre_count;
		logic [31:0] post_count;
	} eng_state_s;

endpackage : ai_timing_pkg

/* File: hdl/ai_sample_timing_engine.sv */
/*
 * Acquisition sample counter and sample clock selection.
 * Assumes synchronous trigger and clock inputs and a single system clock.
 */
// Implementation choices: strobed register access and the register addresses.
// Contract
// - Posttrigger run loads posttrigger count at start
// - Decrement per sample; stop at zero
// - Pretrigger run loads pretrigger count at start
// - Pretrigger zero reloads posttrigger count; code clears it and loads it at reference
// - Start trigger is hardware or software
// - Software start pulses the start line
// - Reference before full pretrigger is ignored
// - After reference, count posttrigger samples then stop
// - Each sample clock samples every channel
// - Internal/external source, selectable edge
// - Internal: counter, divided timebase, software pulse
// - Divided clock from programmable divider
// - External: 16 inputs, 8 bus lines, star, compare
// - Start-to-first-sample delay, default two ticks; code applies it only with an internal source
// - Start runs internal counter; stop ends it
`timescale 1ns/1ns

module ai_sample_timing_engine #(
	parameter int CNT_W = 32
) (
	input  wire logic                     clk_sys_i,
	input  wire logic                     nrst_i,
	input  wire logic [3:0]               addr_i,
	input  wire logic [31:0]              wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [31:0]              rdata_o,
	input  wire logic                     timebase_tick_i,
	input  wire logic                     counter_out_i,
	input  wire ai_timing_pkg::ext_lines_s ext_lines_i,
	input  wire logic                     acquisition_start_trigger_i,
	input  wire logic                     acquisition_reference_trigger_i,
	output logic                          start_trigger_line_o,
	output logic                          sample_clock_o,
	output logic                          acq_busy_o,
	output logic                          acq_done_o
);

`include "ai_timing_cfg.svh"

	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
		$error("CNT_W must lie in 2..32");
	end

	ai_timing_pkg::eng_state_s q, d;

	logic ext_level;
	logic int_level;
	logic sel_level;
	logic sel_edge;
	logic start_edge;
	logic ref_edge;
	logic wr_cmd;
	logic [31:0] rd_mux;

	// ------------------------------------------------------------------
	// Clock source selection
	// ------------------------------------------------------------------
	always_comb begin
		// 26 external lines; codes above 25 read as idle low
		unique case (q.src_sel) inside
			[5'd0:5'd15]:  ext_level = ext_lines_i.programmable_function_input[q.src_sel[3:0]];
			[5'd16:5'd23]: ext_level = ext_lines_i.trig_bus[q.src_sel[2:0]];
			5'd24:         ext_level = ext_lines_i.star;
			5'd25:         ext_level = ext_lines_i.analog_cmp;
			default:       ext_level = 1'b0;
		endcase
	end

	assign int_level = (q.src_sel[1:0] == ai_timing_pkg::SRC_COUNTER)
		? counter_out_i : 1'b0;
	assign sel_level = q.ext_clk ? ext_level : int_level;
	assign sel_edge  = q.clk_fall ? (q.clk_prev & ~sel_level)
		: (~q.clk_prev & sel_level);
	assign start_edge = q.start_fall
		? (q.start_prev & ~acquisition_start_trigger_i)
		: (~q.start_prev & acquisition_start_trigger_i);
	assign ref_edge = q.ref_fall
		? (q.ref_prev & ~acquisition_reference_trigger_i)
		: (~q.ref_prev & acquisition_reference_trigger_i);
	assign wr_cmd = wr_i && addr_i == `REG_COMMAND;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic go;
		logic tick;
		logic div_tick;
		logic internal;
		logic hit;
		go       = 1'b0;
		tick     = 1'b0;
		div_tick = 1'b0;
		internal = 1'b0;
		hit      = 1'b0;
		d = q;
		d.clk_prev   = sel_level;
		d.start_prev = acquisition_start_trigger_i;
		d.ref_prev   = acquisition_reference_trigger_i;
		d.sample     = 1'b0;
		d.start_out  = 1'b0;
		d.rdata      = 32'h0000_0000;

		if (wr_i) begin
			unique case (addr_i)
				`REG_CTRL: begin
					d.pretrig    = wdata_i[`CTRL_PRETRIG];
					d.sw_start   = wdata_i[`CTRL_SW_START];
					d.start_fall = wdata_i[`CTRL_START_FALL];
					d.ref_fall   = wdata_i[`CTRL_REF_FALL];
				end
				`REG_CLKSEL: begin
					d.ext_clk  = wdata_i[`CLKSEL_EXT];
					d.clk_fall = wdata_i[`CLKSEL_FALL];
					d.src_sel  = wdata_i[`CLKSEL_SRC_LO +: 5];
				end
				`REG_DIVIDER:    d.divider    = wdata_i;
				`REG_DELAY:      d.delay      = wdata_i;
				`REG_PRE_COUNT:  d.pre_count  = wdata_i;
				`REG_POST_COUNT: d.post_count = wdata_i;
				default: ;
			endcase
		end

		internal = !q.ext_clk;
		// Divider and delay run only on timebase ticks
		if (q.state == ai_timing_pkg::ST_PRE
			|| q.state == ai_timing_pkg::ST_WAITREF
			|| q.state == ai_timing_pkg::ST_POST) begin
			if (timebase_tick_i) begin
				if (q.div_cnt <= 32'h0000_0001) begin
					d.div_cnt = q.divider;
					div_tick  = 1'b1;
				end else begin
					d.div_cnt = q.div_cnt - 32'h0000_0001;
				end
			end
		end

		if (internal
			&& q.src_sel[1:0] == ai_timing_pkg::SRC_DIVIDED)
			tick = div_tick;
		else if (internal && q.src_sel[1:0] == ai_timing_pkg::SRC_SOFT)
			tick = wr_cmd && wdata_i[`CMD_SW_SAMPLE];
		else
			tick = sel_edge;

		// Clearing done loses to a simultaneous completion
		if (wr_cmd && wdata_i[`CMD_CLR_DONE])
			d.done = 1'b0;

		unique case (q.state)
			ai_timing_pkg::ST_IDLE: begin
				if (wr_cmd && wdata_i[`CMD_ARM])
					d.state = ai_timing_pkg::ST_ARMED;
			end
			ai_timing_pkg::ST_ARMED: begin
				if (q.sw_start)
					go = wr_cmd && wdata_i[`CMD_SW_START];
				else
					go = start_edge;
				if (go) begin
					d.start_out = q.sw_start;
					d.done      = 1'b0;
					d.div_cnt   = q.divider;
					d.count = q.pretrig ? q.pre_count
						: q.post_count;
					if (internal) begin
						d.dly_cnt = q.delay;
						d.state   = ai_timing_pkg::ST_DELAY;
					end else begin
						d.state = q.pretrig ? ai_timing_pkg::ST_PRE
							: ai_timing_pkg::ST_POST;
					end
				end
			end
			ai_timing_pkg::ST_DELAY: begin
				if (timebase_tick_i) begin
					if (q.dly_cnt <= 32'h0000_0001) begin
						d.sample  = 1'b1;
						hit       = 1'b1;
						d.div_cnt = q.divider;
						d.state   = q.pretrig ? ai_timing_pkg::ST_PRE
							: ai_timing_pkg::ST_POST;
					end else begin
						d.dly_cnt = q.dly_cnt - 32'h0000_0001;
					end
				end
			end
			ai_timing_pkg::ST_PRE: begin
				if (tick) begin
					d.sample = 1'b1;
					hit      = 1'b1;
				end
			end
			ai_timing_pkg::ST_WAITREF: begin
				if (tick)
					d.sample = 1'b1;
				if (ref_edge) begin
					d.count = q.post_count;
					d.state = ai_timing_pkg::ST_POST;
				end
			end
			ai_timing_pkg::ST_POST: begin
				if (tick) begin
					d.sample = 1'b1;
					hit      = 1'b1;
				end
			end
			default: d.state = ai_timing_pkg::ST_IDLE;
		endcase

		if (hit) begin
			if (d.state == ai_timing_pkg::ST_PRE) begin
				d.count = q.count - 32'h0000_0001;
				if (q.count <= 32'h0000_0001) begin
					d.count = 32'h0000_0000;
					// Reference listened to only from here on
					d.state = ai_timing_pkg::ST_WAITREF;
				end
			end else begin
				d.count = q.count - 32'h0000_0001;
				if (q.count <= 32'h0000_0001) begin
					d.count = 32'h0000_0000;
					d.done  = 1'b1;
					d.state = ai_timing_pkg::ST_IDLE;
				end
			end
		end

		if (wr_cmd && wdata_i[`CMD_STOP])
			d.state = ai_timing_pkg::ST_IDLE;

		if (rd_i)
			d.rdata = rd_mux;
	end

	// ------------------------------------------------------------------
	// Register read map
	// ------------------------------------------------------------------
	always_comb begin
		unique case (addr_i)
			`REG_CTRL:       rd_mux = {28'h0000_000, q.ref_fall,
				q.start_fall, q.sw_start, q.pretrig};
			`REG_CLKSEL:     rd_mux = {23'h00_0000, q.src_sel, 2'h0,
				q.clk_fall, q.ext_clk};
			`REG_DIVIDER:    rd_mux = q.divider;
			`REG_DELAY:      rd_mux = q.delay;
			`REG_PRE_COUNT:  rd_mux = q.pre_count;
			`REG_POST_COUNT: rd_mux = q.post_count;
			`REG_STATUS:     rd_mux = {27'h000_0000, q.state, 1'b0,
				q.done};
			`REG_COUNT:      rd_mux = q.count;
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q         <= '0;
			q.state   <= ai_timing_pkg::ST_IDLE;
			q.divider <= `DIVIDER_RESET;
			q.delay   <= `DELAY_RESET;
		end else begin
			q <= d;
		end
	end

	assign rdata_o              = q.rdata;
	assign start_trigger_line_o = q.start_out;
	assign sample_clock_o       = q.sample;
	assign acq_done_o           = q.done;
	assign acq_busy_o           = q.state != ai_timing_pkg::ST_IDLE
		&& q.state != ai_timing_pkg::ST_ARMED;

endmodule : ai_sample_timing_engine

/* File: tb/ai_timing_checker.sv */
/* Port checker for the sample timing engine, bound to its top module.
 * Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ns
module ai_timing_checker (
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	input wire logic [3:0]  addr_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        start_trigger_line_o,
	input wire logic        sample_clock_o,
	input wire logic        acq_busy_o,
	input wire logic        acq_done_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	property p_rdata_idle; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stray rdata");
	property p_unmapped;
		$past(rd_i) && $past(addr_i) > 4'h8 |-> rdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped nonzero");
	property p_start_one; start_trigger_line_o |=> !start_trigger_line_o;
	endproperty
	a_start_one: assert property (p_start_one) else $error("start pulse long");
	property p_start_busy; start_trigger_line_o |-> acq_busy_o; endproperty
	a_start_busy: assert property (p_start_busy) else $error("start idle");
	property p_sample_run; sample_clock_o |-> $past(acq_busy_o); endproperty
	a_sample_run: assert property (p_sample_run) else $error("idle sample");
	property p_done_last;
		$rose(acq_done_o) |-> sample_clock_o && !acq_busy_o;
	endproperty
	a_done_last: assert property (p_done_last) else $error("done early");
	property p_busy_end; $fell(acq_busy_o) |-> acq_done_o || $past(wr_i);
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("run cut");
	property p_done_hold; $fell(acq_done_o) |-> $past(wr_i) || acq_busy_o;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done lost");
endmodule : ai_timing_checker

bind ai_sample_timing_engine ai_timing_checker i_ai_timing_checker (
	.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o),
	.start_trigger_line_o(start_trigger_line_o),
	.sample_clock_o(sample_clock_o), .acq_busy_o(acq_busy_o),
	.acq_done_o(acq_done_o));

/* File: tb/terminal_model.sv */
/* Far-side terminals: timebase ticks, counter output and external lines.
 * Assumes the bench picks the clocked line and enables its pulses. */
`timescale 1ns/1ns
module terminal_model (
	input  wire logic                 clk_sys_i,
	input  wire logic                 nrst_i,
	input  wire logic [4:0]           sel_i,
	input  wire logic                 pulse_en_i,
	output ai_timing_pkg::ext_lines_s ext_lines_o,
	output logic                      timebase_tick_o,
	output logic                      counter_out_o
);
	logic [7:0]  phase_q;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin : p_lines
		logic [25:0] lines;
		int          b;
		lines = '0;
		b = 0;
		if (!nrst_i) begin
			phase_q <= 8'h0;
			ext_lines_o <= '0;
			timebase_tick_o <= 1'b0;
			counter_out_o <= 1'b0;
		end else begin
			phase_q <= phase_q + 8'h1;
			timebase_tick_o <= phase_q[1:0] == 2'h3;
			counter_out_o <= phase_q % 10 < 5;
			// Unused lines carry noise so a wrong selection shows up
			lines = $urandom;
			b = sel_i < 16 ? 10 + sel_i : sel_i < 24 ? sel_i - 14 : 25 - sel_i;
			lines[b] = pulse_en_i && phase_q % 6 < 3;
			ext_lines_o <= lines;
		end
	end
endmodule : terminal_model

/* File: tb/ai_sample_timing_engine_bench.sv */
/* Self-checking bench for the sample timing engine.
 * Assumes the register map and field positions of the timing header. */
`timescale 1ns/1ns
`include "ai_timing_cfg.svh"
module ai_sample_timing_engine_bench;
	logic        clk_sys_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic        wr_i = 1'b0, rd_i = 1'b0, st_i = 1'b0, ref_i = 1'b0;
	logic        pen = 1'b0;
	logic [4:0]  sel = 5'h0;
	logic [31:0] rdata_o, v;
	logic        start_line, samp, busy, done, tick, cnt_out;
	ai_timing_pkg::ext_lines_s lines;
	int          mismatches = 0, tests_run = 0, n, src, post;

	always #10 clk_sys_i = ~clk_sys_i;

	ai_sample_timing_engine i_ai_sample_timing_engine (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.timebase_tick_i(tick), .counter_out_i(cnt_out), .ext_lines_i(lines),
		.acquisition_start_trigger_i(st_i),
		.acquisition_reference_trigger_i(ref_i),
		.start_trigger_line_o(start_line), .sample_clock_o(samp),
		.acq_busy_o(busy), .acq_done_o(done));
	terminal_model i_terminal_model (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sel_i(sel), .pulse_en_i(pen),
		.ext_lines_o(lines), .timebase_tick_o(tick),
		.counter_out_o(cnt_out));

	function automatic logic [31:0] clksel(input logic e, f, input int s);
		return (32'(s) << `CLKSEL_SRC_LO) | (32'(f) << `CLKSEL_FALL) | 32'(e);
	endfunction : clksel

	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rd
	task automatic pulse(input bit r);
		@(posedge clk_sys_i);
		if (r) ref_i <= 1'b1;
		else st_i <= 1'b1;
		@(posedge clk_sys_i);
		ref_i <= 1'b0;
		st_i <= 1'b0;
	endtask : pulse
	task automatic sw_start();
		int p;
		p = 0;
		wr(`REG_COMMAND, 32'h1 << `CMD_ARM);
		wr(`REG_COMMAND, 32'h1 << `CMD_SW_START);
		repeat (3) begin
			#1 if (start_line === 1'b1) p++;
			@(posedge clk_sys_i);
		end
		chk(32'(p), 32'h1);
	endtask : sw_start
	task automatic wait_samples(input int k);
		for (int c = 0; c < 500 && k > 0; c++) begin
			@(posedge clk_sys_i);
			#1 if (samp === 1'b1) k--;
		end
		chk(32'(k), 32'h0);
	endtask : wait_samples
	// Counts sample pulses until done; with swp set, software pulses every fourth cycle
	task automatic count_run(input bit swp, output int m);
		m = 0;
		for (int c = 0; c < 600 && done !== 1'b1; c++) begin
			@(posedge clk_sys_i);
			addr_i <= `REG_COMMAND;
			wdata_i <= 32'h1 << `CMD_SW_SAMPLE;
			wr_i <= swp && c % 4 == 0;
			#1 if (samp === 1'b1) m++;
		end
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask : count_run
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(93));
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rd(`REG_DIVIDER, v);
		chk(v, `DIVIDER_RESET);
		rd(`REG_DELAY, v);
		chk(v, `DELAY_RESET);
		rd(4'hf, v);
		chk(v, 32'h0);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			src = $urandom_range(25);
			post = $urandom_range(5, 1);
			sel <= src[4:0];
			wr(`REG_CTRL, 32'h1 << `CTRL_SW_START);
			wr(`REG_CLKSEL, clksel(1'b1, i[0], src));
			wr(`REG_POST_COUNT, 32'(post));
			sw_start();
			pen <= 1'b1;
			count_run(1'b0, n);
			pen <= 1'b0;
			chk(32'(n), 32'(post));
			chk(32'(done), 32'h1);
		end
		$display("external posttrigger test done");
		for (int s = 0; s < 3; s++) begin
			wr(`REG_CLKSEL, clksel(1'b0, 1'b0, s));
			wr(`REG_POST_COUNT, 32'h2);
			sw_start();
			count_run(s == 2, n);
			chk(32'(n), 32'h2);
		end
		$display("internal source test done");
		wr(`REG_CTRL, 32'h1 << `CTRL_PRETRIG);
		wr(`REG_CLKSEL, clksel(1'b0, 1'b0, 1));
		wr(`REG_PRE_COUNT, 32'h3);
		wr(`REG_COMMAND, 32'h1 << `CMD_ARM);
		pulse(1'b0);
		#1 chk(32'(start_line), 32'h0);
		wait_samples(1);
		pulse(1'b1);
		wait_samples(2);
		rd(`REG_STATUS, v);
		chk(32'(v[4:2]), 32'(ai_timing_pkg::ST_WAITREF));
		pulse(1'b1);
		count_run(1'b0, n);
		chk(32'(n), 32'h2);
		$display("pretrigger test done");
		sel <= 5'h0;
		wr(`REG_CTRL, 32'h1 << `CTRL_SW_START);
		wr(`REG_CLKSEL, clksel(1'b1, 1'b0, 0));
		wr(`REG_POST_COUNT, 32'h5);
		sw_start();
		pen <= 1'b1;
		wait_samples(2);
		wr(`REG_COMMAND, 32'h1 << `CMD_STOP);
		@(posedge clk_sys_i);
		#1 chk({30'h0, busy, done}, 32'h0);
		pen <= 1'b0;
		$display("stop test done");
		end_of_test();
	end

	initial begin
		#400000;
		mismatches++;
		end_of_test();
	end
endmodule : ai_sample_timing_engine_bench
